// [dsc_pkg.sv]
// Constants shared by the dual converter serial load control block
package dsc_pkg;
   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 24;
   localparam int unsigned CNT_W      = 5;
   localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
   localparam int unsigned CODE_W     = 16;
   localparam int unsigned CMD_MSB    = 21;
   localparam int unsigned CMD_LSB    = 19;
   localparam int unsigned ADDR_MSB   = 18;
   localparam int unsigned ADDR_LSB   = 16;
   localparam int unsigned REF_ON_BIT = 0;

   // ---------------------------------------------------------------
   // Commands and channel addresses
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_WRITE_INPUT  = 3'h0,
      CMD_UPDATE_OUT   = 3'h1,
      CMD_WRITE_LOAD   = 3'h2,
      CMD_WRITE_UPDATE = 3'h3,
      CMD_REF_SETUP    = 3'h7
   } dsc_cmd_e;

   localparam logic [2:0] ADDR_CH_A  = 3'h0;
   localparam logic [2:0] ADDR_CH_B  = 3'h1;
   localparam logic [2:0] ADDR_BOTH  = 3'h7;

   // ---------------------------------------------------------------
   // Reset values and synchroniser layout
   // ---------------------------------------------------------------
   localparam logic [CODE_W-1:0] ZERO_SCALE = 16'h0000;
   localparam int unsigned SYNC_W      = 5;
   localparam int unsigned IDX_FSYNC   = 0;
   localparam int unsigned IDX_SCLK    = 1;
   localparam int unsigned IDX_SDATA   = 2;
   localparam int unsigned IDX_LOAD    = 3;
   localparam int unsigned IDX_CLEAR   = 4;
   // Idle levels: frame sync, clock, strobe and clear all rest high
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h1B;
endpackage

// [dsc_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module dsc_sync #(
   parameter int unsigned        W    = 1,
   parameter logic [W-1:0]       INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= INIT;
         q        <= INIT;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [dsc_dac_ctrl.sv]
// Serial load control for a dual voltage-output converter
`timescale 1ns/10ps
`default_nettype none
module dsc_dac_ctrl (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       frameSyncN,
   input  wire logic                       serialClk,
   input  wire logic                       serialData,
   input  wire logic                       loadStrobeN,
   input  wire logic                       asyncClearN,
   output var  logic [dsc_pkg::CODE_W-1:0] outputChannelA,
   output var  logic [dsc_pkg::CODE_W-1:0] outputChannelB,
   output var  logic                       clearModeActive,
   output var  logic                       referencePinOut,
   output var  logic                       referencePinOe
);
   // ---------------------------------------------------------------
   // Input synchronisation and edge detection
   // ---------------------------------------------------------------
   logic [dsc_pkg::SYNC_W-1:0] pinRaw;
   logic [dsc_pkg::SYNC_W-1:0] pinSync;
   logic                       sclkPrev_reg;
   logic                       clearPrev_reg;
   logic                       fsyncN;
   logic                       sclkFall;
   logic                       clearFall;
   logic                       loadLow;
   logic                       clearLow;
   logic                       dataBit;

   assign pinRaw = {asyncClearN, loadStrobeN, serialData, serialClk, frameSyncN};

   dsc_sync #(
      .W    (dsc_pkg::SYNC_W),
      .INIT (dsc_pkg::SYNC_IDLE)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (pinRaw),
      .q   (pinSync)
   );

   assign fsyncN   = pinSync[dsc_pkg::IDX_FSYNC];
   assign dataBit  = pinSync[dsc_pkg::IDX_SDATA];
   assign loadLow  = ~pinSync[dsc_pkg::IDX_LOAD];
   assign clearLow = ~pinSync[dsc_pkg::IDX_CLEAR];
   assign sclkFall = sclkPrev_reg & ~pinSync[dsc_pkg::IDX_SCLK];
   // Edge taken from the synchronised level, so no clock is needed on the pin
   assign clearFall = clearPrev_reg & clearLow;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclkPrev_reg  <= 1'b1;
         clearPrev_reg <= 1'b1;
      end else begin
         sclkPrev_reg  <= pinSync[dsc_pkg::IDX_SCLK];
         clearPrev_reg <= ~clearLow;
      end
   end

   // ---------------------------------------------------------------
   // Frame reception
   // ---------------------------------------------------------------
   logic [dsc_pkg::FRAME_BITS-1:0] shift_reg;
   logic [dsc_pkg::FRAME_BITS-1:0] shiftNext;
   logic [dsc_pkg::CNT_W-1:0]      bitCnt_reg;
   logic                           frameDone_reg;
   logic                           frameKill_reg;
   logic                           frameHit;

   assign shiftNext = {shift_reg[dsc_pkg::FRAME_BITS-2:0], dataBit};
   // The 24th edge counts only while sync is still low and nothing aborted it
   assign frameHit = ~fsyncN & sclkFall & ~frameDone_reg & ~frameKill_reg & ~clearFall
                     & (bitCnt_reg == dsc_pkg::FRAME_LAST);

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_reg     <= '0;
         bitCnt_reg    <= '0;
         frameDone_reg <= 1'b0;
         frameKill_reg <= 1'b0;
      end else if (fsyncN) begin
         // Early rise clears the count and flags but leaves shift_reg untouched; partial bits dropped
         bitCnt_reg    <= '0;
         frameDone_reg <= 1'b0;
         frameKill_reg <= 1'b0;
      end else if (clearFall) begin
         bitCnt_reg    <= '0;
         frameKill_reg <= 1'b1;
      end else if (sclkFall && !frameDone_reg && !frameKill_reg) begin
         shift_reg <= shiftNext;
         if (bitCnt_reg == dsc_pkg::FRAME_LAST) begin
            frameDone_reg <= 1'b1;
         end else begin
            bitCnt_reg <= bitCnt_reg + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Command decode of the completed frame
   // ---------------------------------------------------------------
   logic [2:0]                 cmdField;
   logic [2:0]                 addrField;
   logic [dsc_pkg::CODE_W-1:0] codeField;
   logic                       selA;
   logic                       selB;
   logic                       wrInput;
   logic                       updOut;
   logic                       wrLoadAll;

   assign cmdField  = shiftNext[dsc_pkg::CMD_MSB:dsc_pkg::CMD_LSB];
   assign addrField = shiftNext[dsc_pkg::ADDR_MSB:dsc_pkg::ADDR_LSB];
   assign codeField = shiftNext[dsc_pkg::CODE_W-1:0];
   assign selA      = (addrField == dsc_pkg::ADDR_CH_A) | (addrField == dsc_pkg::ADDR_BOTH);
   assign selB      = (addrField == dsc_pkg::ADDR_CH_B) | (addrField == dsc_pkg::ADDR_BOTH);

   always_comb begin
      wrInput   = 1'b0;
      updOut    = 1'b0;
      wrLoadAll = 1'b0;
      if (frameHit) begin
         unique case (cmdField)
            dsc_pkg::CMD_WRITE_INPUT:  wrInput = 1'b1;
            dsc_pkg::CMD_UPDATE_OUT:   updOut = 1'b1;
            dsc_pkg::CMD_WRITE_LOAD: begin
               wrInput   = 1'b1;
               wrLoadAll = 1'b1;
            end
            dsc_pkg::CMD_WRITE_UPDATE: begin
               wrInput = 1'b1;
               updOut  = 1'b1;
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Channel input and output registers
   // ---------------------------------------------------------------
   logic [dsc_pkg::CODE_W-1:0] inA_reg;
   logic [dsc_pkg::CODE_W-1:0] inB_reg;
   logic                       newA_reg;
   logic                       newB_reg;
   logic                       strobeOk;

   // A held-low strobe behaves as a continuous transfer of fresh data while the clear pin is high
   assign strobeOk = loadLow & ~clearLow;

   always_ff @(posedge clk) begin
      if (rst || clearFall) begin
         inA_reg  <= dsc_pkg::ZERO_SCALE;
         inB_reg  <= dsc_pkg::ZERO_SCALE;
         newA_reg <= 1'b0;
         newB_reg <= 1'b0;
      end else begin
         if (wrInput && selA) begin
            inA_reg  <= codeField;
            newA_reg <= ~(updOut | wrLoadAll);
         end else if (strobeOk || (updOut && selA) || wrLoadAll) begin
            newA_reg <= 1'b0;
         end
         if (wrInput && selB) begin
            inB_reg  <= codeField;
            newB_reg <= ~(updOut | wrLoadAll);
         end else if (strobeOk || (updOut && selB) || wrLoadAll) begin
            newB_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clearFall) begin
         outputChannelA <= dsc_pkg::ZERO_SCALE;
         outputChannelB <= dsc_pkg::ZERO_SCALE;
      end else begin
         if (wrInput && selA && (updOut || wrLoadAll)) begin
            outputChannelA <= codeField;
         end else if ((updOut && selA) || wrLoadAll || (strobeOk && newA_reg)) begin
            outputChannelA <= inA_reg;
         end
         if (wrInput && selB && (updOut || wrLoadAll)) begin
            outputChannelB <= codeField;
         end else if ((updOut && selB) || wrLoadAll || (strobeOk && newB_reg)) begin
            outputChannelB <= inB_reg;
         end
      end
   end

   // ---------------------------------------------------------------
   // Clear-code mode and reference pin direction
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         clearModeActive <= 1'b0;
      end else if (clearFall) begin
         clearModeActive <= 1'b1;
      end else if (frameHit) begin
         clearModeActive <= 1'b0;
      end
   end

   // Pin stays an input until software selects the internal reference
   always_ff @(posedge clk) begin
      if (rst) begin
         referencePinOut <= 1'b0;
         referencePinOe  <= 1'b0;
      end else if (frameHit && cmdField == dsc_pkg::CMD_REF_SETUP) begin
         referencePinOut <= shiftNext[dsc_pkg::REF_ON_BIT];
         referencePinOe  <= shiftNext[dsc_pkg::REF_ON_BIT];
      end
   end
endmodule
`default_nettype wire

// [dsc_dac_ctrl_props.sv]
// Concurrent checks on the ports of the serial load control block
`timescale 1ns/10ps
`default_nettype none
module dsc_dac_ctrl_props (
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic                       frameSyncN,
   input wire logic                       serialClk,
   input wire logic                       serialData,
   input wire logic                       loadStrobeN,
   input wire logic                       asyncClearN,
   input wire logic [dsc_pkg::CODE_W-1:0] outputChannelA,
   input wire logic [dsc_pkg::CODE_W-1:0] outputChannelB,
   input wire logic                       clearModeActive,
   input wire logic                       referencePinOut,
   input wire logic                       referencePinOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Eight quiet cycles cover the pin synchroniser latency
   sequence quiet_s; (loadStrobeN && asyncClearN && frameSyncN) [*8]; endsequence
   sequence cleared_s; (!asyncClearN && frameSyncN) [*8]; endsequence
   reset_zero_a: assert property ($fell(rst) |-> outputChannelA == 16'h0000 && !clearModeActive && !referencePinOe)
      else $error("state not cleared by reset");
   ref_oe_a: assert property (referencePinOe == referencePinOut) else $error("reference enable mismatch");
   ref_change_a: assert property ($changed(referencePinOe) |-> !$past(frameSyncN, 3))
      else $error("reference pin changed outside a frame");
   clear_zero_a: assert property ($fell(asyncClearN) |-> ##[1:6] (outputChannelA == 16'h0000 &&
      outputChannelB == 16'h0000 && clearModeActive)) else $error("clear did not zero outputs");
   clear_set_a: assert property ($rose(clearModeActive) |-> !$past(asyncClearN, 2))
      else $error("clear mode without clear edge");
   clear_exit_a: assert property ($fell(clearModeActive) |-> !$past(frameSyncN, 3))
      else $error("clear mode left outside a frame");
   clear_hold_a: assert property (cleared_s |-> $stable(outputChannelA) && $stable(outputChannelB))
      else $error("outputs moved while clear held");
   quiet_stable_a: assert property (quiet_s |-> $stable(outputChannelA) && $stable(outputChannelB))
      else $error("outputs moved while idle");
endmodule
bind dsc_dac_ctrl dsc_dac_ctrl_props i_props (.clk(clk), .rst(rst), .frameSyncN(frameSyncN),
   .serialClk(serialClk), .serialData(serialData), .loadStrobeN(loadStrobeN), .asyncClearN(asyncClearN),
   .outputChannelA(outputChannelA), .outputChannelB(outputChannelB), .clearModeActive(clearModeActive),
   .referencePinOut(referencePinOut), .referencePinOe(referencePinOe));
`default_nettype wire

// [dsc_host_model.sv]
// Behavioural host writing frames over the three-wire link
`timescale 1ns/10ps
`default_nettype none
module dsc_host_model (
   input  wire logic clk,
   output var  logic frameSyncN,
   output var  logic serialClk,
   output var  logic serialData
);
   initial begin
      frameSyncN = 1'b1;
      serialClk  = 1'b1;
      serialData = 1'b0;
   end
   // Half period of 4 clk (400 ns) gives an 800 ns bit period, well under the link limit
   task automatic send(input logic [23:0] w, input int n);
      @(posedge clk) frameSyncN <= 1'b0;
      for (int i = 0; i < n; i++) begin
         serialData <= w[23-i];
         repeat (4) @(posedge clk);
         serialClk <= 1'b0;
         repeat (4) @(posedge clk);
         serialClk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      frameSyncN <= 1'b1;
      // Released data line must not keep showing the last bit
      serialData <= ~serialData;
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [dsc_dac_ctrl_tb.sv]
// Self-checking bench for the serial load control block
`timescale 1ns/10ps
`default_nettype none
module dsc_dac_ctrl_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        loadStrobeN = 1'b1;
   logic        asyncClearN = 1'b1;
   wire logic   frameSyncN, serialClk, serialData;
   logic [15:0] outputChannelA, outputChannelB, a, b;
   logic        clearModeActive, referencePinOut, referencePinOe;
   logic [31:0] seed = 32'hC6639F64;
   logic [31:0] seen = 32'h0;
   logic [31:0] notes[$];
   int          numErrors = 0;
   int          totalChecks = 0;
   always #50 clk = ~clk;
   dsc_host_model i_host (.clk(clk), .frameSyncN(frameSyncN), .serialClk(serialClk), .serialData(serialData));
   dsc_dac_ctrl i_dut (.clk(clk), .rst(rst), .frameSyncN(frameSyncN), .serialClk(serialClk),
      .serialData(serialData), .loadStrobeN(loadStrobeN), .asyncClearN(asyncClearN),
      .outputChannelA(outputChannelA), .outputChannelB(outputChannelB), .clearModeActive(clearModeActive),
      .referencePinOut(referencePinOut), .referencePinOe(referencePinOe));
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic logic [23:0] fr(input logic [2:0] c, input logic [2:0] ad, input logic [15:0] d);
      return {2'b00, c, ad, d};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reportAndStop();
      $display("Checks %0d mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic settle();
      int n;
      n = 0;
      while (notes.size() != 0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (notes.size() != 0) begin
         numErrors++;
         $display("Error pending notes expected 0 seen %0d", notes.size());
         reportAndStop();
      end else begin
         repeat (6) @(posedge clk);
      end
   endtask
   task automatic tx(input logic [23:0] w, input int n = 24);
      i_host.send(w, n);
      settle();
   endtask
   task automatic pulse();
      @(posedge clk) loadStrobeN <= 1'b0;
      repeat (4) @(posedge clk);
      loadStrobeN <= 1'b1;
      settle();
   endtask
   // Each output change takes the oldest expected pair off the queue
   always @(negedge clk) begin
      if (!rst && {outputChannelA, outputChannelB} !== seen) begin
         seen = {outputChannelA, outputChannelB};
         chk("output pair", (notes.size() != 0) ? notes.pop_front() : ~seen, seen);
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("reset flags", 3'b000, {clearModeActive, referencePinOe, referencePinOut});
      tx(fr(dsc_pkg::CMD_REF_SETUP, 3'h0, 16'h0001));
      chk("reference pin", 2'b11, {referencePinOe, referencePinOut});
      tx(fr(dsc_pkg::CMD_REF_SETUP, 3'h0, 16'h0000));
      chk("reference pin", 2'b00, {referencePinOe, referencePinOut});
      $display("Test reference done");
      a = rnd();
      b = rnd();
      tx(fr(dsc_pkg::CMD_WRITE_INPUT, dsc_pkg::ADDR_CH_A, a));
      tx(fr(dsc_pkg::CMD_WRITE_INPUT, dsc_pkg::ADDR_CH_B, b));
      notes.push_back({a, b});
      pulse();
      loadStrobeN <= 1'b0;
      a = rnd();
      notes.push_back({a, b});
      tx(fr(dsc_pkg::CMD_WRITE_INPUT, dsc_pkg::ADDR_CH_A, a));
      loadStrobeN <= 1'b1;
      $display("Test load strobe done");
      b = rnd();
      tx(fr(dsc_pkg::CMD_WRITE_UPDATE, dsc_pkg::ADDR_CH_B, b), 23);
      notes.push_back({a, b});
      tx(fr(dsc_pkg::CMD_WRITE_UPDATE, dsc_pkg::ADDR_CH_B, b));
      a = rnd();
      notes.push_back({a, b});
      tx(fr(dsc_pkg::CMD_WRITE_LOAD, dsc_pkg::ADDR_CH_A, a));
      a = rnd();
      tx(fr(dsc_pkg::CMD_WRITE_INPUT, dsc_pkg::ADDR_CH_A, a));
      notes.push_back({a, b});
      tx(fr(dsc_pkg::CMD_UPDATE_OUT, dsc_pkg::ADDR_CH_A, 16'h0000));
      a = rnd();
      b = a;
      notes.push_back({a, b});
      tx(fr(dsc_pkg::CMD_WRITE_UPDATE, dsc_pkg::ADDR_BOTH, a));
      tx(fr(dsc_pkg::CMD_WRITE_UPDATE, 3'h2, rnd()));
      $display("Test commands done");
      asyncClearN <= 1'b0;
      notes.push_back(32'h0);
      settle();
      chk("clear mode", 1'b1, clearModeActive);
      tx(fr(dsc_pkg::CMD_WRITE_INPUT, dsc_pkg::ADDR_CH_A, a), 23);
      chk("clear mode", 1'b1, clearModeActive);
      a = rnd();
      tx(fr(dsc_pkg::CMD_WRITE_INPUT, dsc_pkg::ADDR_CH_A, a));
      chk("clear mode", 1'b0, clearModeActive);
      pulse();
      asyncClearN <= 1'b1;
      notes.push_back({a, 16'h0000});
      pulse();
      $display("Test clear done");
      fork
         tx(fr(dsc_pkg::CMD_WRITE_UPDATE, dsc_pkg::ADDR_CH_B, rnd()));
         begin
            repeat (100) @(posedge clk);
            asyncClearN <= 1'b0;
            notes.push_back(32'h0);
         end
      join
      asyncClearN <= 1'b1;
      b = rnd();
      notes.push_back({16'h0000, b});
      tx(fr(dsc_pkg::CMD_WRITE_UPDATE, dsc_pkg::ADDR_CH_B, b));
      chk("pending notes", 32'h0, notes.size());
      $display("Test abort done");
      reportAndStop();
   end
endmodule
`default_nettype wire
